// file: rtl/hsp_port.sv
// Operation
// [RL1] Internal register accesses are always whole 32-bit quadlets.
// [RL2] Low two address bits pick the read shadow byte combinationally.
// [RL3] Read with update copies the indexed register into the read shadow.
// [RL4] Read without update leaves the read shadow as it is.
// [RL5] Read shadow bytes may be read in any order, any number of times.
// [RL6] Each write stores one byte lane of the write shadow.
// [RL7] Write with update stores the byte, then copies the quadlet out.
// [RL8] Unwritten write shadow lanes keep old values and go out too.
// [RL9] Without update the register index lines are ignored.
// [RL10] Lane zero is the most significant byte; address is 4N plus lane.
// [RL11] Reading a receive queue index pops its oldest quadlet into the shadow.
// [RL12] Host fetches all four popped bytes before any other read.
// [RL13] Each transmit queue has a next index and a last index.
// [RL14] Update write to a transmit index appends the quadlet to the queue.
// [RL15] Queue access may lag; availability flags are shown to the host.
// [RL16] A transfer holder sits between host and queue storage.
// [RL17] A cycle starts when chip select and a strobe are both low.
// [RL18] Both strobes low under chip select gives a write cycle.
// [RL19] Host control lines are resynchronised to the core clock.
// [RL20] Host leaves more than two core clocks idle between accesses.
// [RL21] Interrupt request is an active-low open-drain output.
// [RL22] Nine address inputs, eight data lines, three active-low strobes.
// [RL23] Sixty-four quadlet register indices selected by six bits.
// [RL24] One pop or push per host cycle with update, however long.
`timescale 1ns/10ps
`default_nettype none
module hsp_port #(
    parameter int NRX = hsp_pkg::NUM_RXQ,
    parameter int NTX = hsp_pkg::NUM_TXQ
) (
    input wire logic CLK,
    input wire logic RST_B,
    // [RL22] host pin set
    input wire logic BYTE_LANE_SELECT_LOW,
    input wire logic BYTE_LANE_SELECT_HIGH,
    input wire logic [hsp_pkg::IDX_W-1:0] REGISTER_INDEX_LINES,
    input wire logic SHADOW_UPDATE_LINE,
    input wire logic HOST_READ_STROBE_N,
    input wire logic HOST_WRITE_STROBE_N,
    input wire logic HOST_CHIP_SELECT_N,
    input wire logic [hsp_pkg::BYTE_W-1:0] HOST_DATA_LINES_IN,
    output logic [hsp_pkg::BYTE_W-1:0] HOST_DATA_LINES_OUT,
    output logic HOST_DATA_LINES_OE,
    output logic HOST_INTERRUPT_REQUEST_N_OUT,
    output logic HOST_INTERRUPT_REQUEST_N_OE,
    input wire logic INT_PENDING,
    output logic [hsp_pkg::IDX_W-1:0] REG_INDEX,
    output logic [hsp_pkg::QUAD_W-1:0] REG_WDATA,
    output logic REG_WR,
    output logic REG_RD,
    input wire logic [hsp_pkg::QUAD_W-1:0] REG_RDATA,
    input wire logic [NRX-1:0][hsp_pkg::QUAD_W-1:0] RXQ_DATA,
    input wire logic [NRX-1:0] RXQ_VALID,
    output logic [NRX-1:0] RXQ_READY,
    output logic [NTX-1:0][hsp_pkg::QUAD_W-1:0] TXQ_DATA,
    output logic [NTX-1:0] TXQ_LAST,
    output logic [NTX-1:0] TXQ_VALID,
    input wire logic [NTX-1:0] TXQ_READY,
    output logic [NRX-1:0] RXQ_AVAIL,
    output logic [NTX-1:0] TXQ_AVAIL,
    output logic RXQ_READ_ERR,
    output logic TXQ_WRITE_ERR
);
    localparam int QW = hsp_pkg::QUAD_W;
    localparam int BW = hsp_pkg::BYTE_W;
    localparam int LW = hsp_pkg::LANE_W;
    localparam int IW = hsp_pkg::IDX_W;

    typedef struct packed {
        hsp_pkg::hsp_state_t st;
        logic [QW-1:0] rshadow;
        logic [QW-1:0] wshadow;
        logic [IW-1:0] idx;
        logic [QW-1:0] wdata;
        logic wr;
        logic rd;
        logic rx_err;
        logic tx_err;
    } hsp_port_t;

    hsp_port_t s;
    hsp_port_t next_s;

    // Byte lane extraction, lane zero being the most significant byte.
    function automatic logic [BW-1:0] lane_pick(
        input logic [QW-1:0] q,
        input logic [LW-1:0] lane
    );
        logic [BW-1:0] r;
        r = hsp_pkg::BYTE_ZERO;
        for (int k = 0; k < hsp_pkg::NUM_LANES; k++) begin
            if (lane == LW'(k)) begin
                r = q[QW-1-k*BW -: BW];
            end
        end
        return r;
    endfunction

    // Replaces one byte lane of a quadlet and keeps the others.
    function automatic logic [QW-1:0] lane_merge(
        input logic [QW-1:0] q,
        input logic [LW-1:0] lane,
        input logic [BW-1:0] b
    );
        logic [QW-1:0] r;
        r = q;
        for (int k = 0; k < hsp_pkg::NUM_LANES; k++) begin
            if (lane == LW'(k)) begin
                r[QW-1-k*BW -: BW] = b;
            end
        end
        return r;
    endfunction

    // Register index of receive queue q.
    function automatic logic [IW-1:0] rx_index(input int q);
        logic [IW-1:0] r;
        r = (q == 0) ? hsp_pkg::RXQ_REQ_IDX : hsp_pkg::RXQ_RSP_IDX;
        return r;
    endfunction

    // Register index of a next or last slot of transmit queue q.
    function automatic logic [IW-1:0] tx_index(input int q, input logic last);
        logic [IW-1:0] r;
        if (q == 0) begin
            r = last ? hsp_pkg::TXQ_REQ_LAST_IDX : hsp_pkg::TXQ_REQ_NEXT_IDX;
        end else begin
            r = last ? hsp_pkg::TXQ_RSP_LAST_IDX : hsp_pkg::TXQ_RSP_NEXT_IDX;
        end
        return r;
    endfunction

    // Two flops keep a strobe edge near CLK away from the state machine.
    // [RL19] control line resync
    logic [hsp_pkg::CTL_W-1:0] ctl_sync;
    logic cs_n_s;
    logic rd_n_s;
    logic wr_n_s;
    hsp_sync #(
        .W(hsp_pkg::CTL_W),
        .RST_VAL('1)
    ) u_sync (
        .clk(CLK),
        .rst_b(RST_B),
        .d({HOST_CHIP_SELECT_N, HOST_READ_STROBE_N, HOST_WRITE_STROBE_N}),
        .q(ctl_sync)
    );
    assign {cs_n_s, rd_n_s, wr_n_s} = ctl_sync;

    logic cs_act;
    logic rd_act;
    logic wr_act;
    logic any_act;
    // [RL17] cycle start condition
    assign cs_act = !cs_n_s;
    // [RL18] write wins over read
    assign wr_act = cs_act && !wr_n_s;
    assign rd_act = cs_act && !rd_n_s && wr_n_s;
    assign any_act = wr_act || rd_act;

    logic [LW-1:0] lane;
    // [RL10] lane from low address bits
    assign lane = {BYTE_LANE_SELECT_HIGH, BYTE_LANE_SELECT_LOW};

    // Status and handshakes between the holders and the state machine.
    logic [NRX-1:0] rx_avail;
    logic [NRX-1:0] rx_pop;
    logic [NRX-1:0][QW-1:0] rx_head;
    logic [NRX-1:0] rx_hit;
    logic [NTX-1:0] tx_room;
    logic [NTX-1:0] tx_push;
    logic [NTX-1:0] tx_hit;
    logic [NTX-1:0] tx_is_last;
    logic [QW-1:0] merged;

    // [RL16] receive transfer holders
    genvar gi;
    generate
        for (gi = 0; gi < NRX; gi++) begin : gen_rx
            hsp_hold_if #(.W(QW)) up_if ();
            hsp_hold_if #(.W(QW)) dn_if ();
            assign up_if.data = RXQ_DATA[gi];
            assign up_if.last = 1'b0;
            assign up_if.valid = RXQ_VALID[gi];
            assign RXQ_READY[gi] = up_if.ready;
            assign rx_avail[gi] = dn_if.valid;
            assign rx_head[gi] = dn_if.data;
            assign dn_if.ready = rx_pop[gi];
            // [RL11] one index per receive queue
            assign rx_hit[gi] = (REGISTER_INDEX_LINES == rx_index(gi));
            hsp_holder #(.W(QW)) u_hold (
                .clk(CLK),
                .rst_b(RST_B),
                .up(up_if),
                .dn(dn_if)
            );
        end
        // [RL16] transmit transfer holders
        for (gi = 0; gi < NTX; gi++) begin : gen_tx
            hsp_hold_if #(.W(QW)) up_if ();
            hsp_hold_if #(.W(QW)) dn_if ();
            // [RL13] next and last indices
            assign tx_is_last[gi] = (REGISTER_INDEX_LINES == tx_index(gi, 1'b1));
            assign tx_hit[gi] = tx_is_last[gi]
                || (REGISTER_INDEX_LINES == tx_index(gi, 1'b0));
            assign up_if.data = merged;
            assign up_if.last = tx_is_last[gi];
            assign up_if.valid = tx_push[gi];
            assign tx_room[gi] = up_if.ready;
            assign TXQ_DATA[gi] = dn_if.data;
            assign TXQ_LAST[gi] = dn_if.last;
            assign TXQ_VALID[gi] = dn_if.valid;
            assign dn_if.ready = TXQ_READY[gi];
            hsp_holder #(.W(QW)) u_hold (
                .clk(CLK),
                .rst_b(RST_B),
                .up(up_if),
                .dn(dn_if)
            );
        end
    endgenerate

    // [RL6] single lane write
    // [RL8] other lanes kept
    assign merged = lane_merge(s.wshadow, lane, HOST_DATA_LINES_IN);

    always_comb begin
        next_s = s;
        next_s.wr = 1'b0;
        next_s.rd = 1'b0;
        next_s.rx_err = 1'b0;
        next_s.tx_err = 1'b0;
        rx_pop = '0;
        tx_push = '0;
        unique case (s.st)
            hsp_pkg::HSP_IDLE: begin
                // [RL24] act once at cycle start
                if (wr_act) begin
                    next_s.st = hsp_pkg::HSP_WRITE;
                    // The byte lands even when the quadlet goes to a queue.
                    next_s.wshadow = merged;
                    // [RL9] index used only with update
                    if (SHADOW_UPDATE_LINE) begin
                        if (|tx_hit) begin
                            // [RL14] append to transmit queue
                            tx_push = tx_hit & tx_room;
                            // A push into a full holder is flagged and dropped.
                            next_s.tx_err = |(tx_hit & ~tx_room);
                        end else begin
                            // [RL7] whole quadlet out
                            next_s.wr = 1'b1;
                            next_s.idx = REGISTER_INDEX_LINES;
                            next_s.wdata = merged;
                        end
                    end
                end else if (rd_act) begin
                    next_s.st = hsp_pkg::HSP_READ;
                    // [RL4] no update keeps shadow
                    if (SHADOW_UPDATE_LINE) begin
                        if (|rx_hit) begin
                            // [RL11] pop head into shadow
                            rx_pop = rx_hit & rx_avail;
                            next_s.rx_err = |(rx_hit & ~rx_avail);
                            for (int q = 0; q < NRX; q++) begin
                                if (rx_pop[q]) begin
                                    next_s.rshadow = rx_head[q];
                                end
                            end
                        end else begin
                            // [RL3] snapshot request
                            next_s.st = hsp_pkg::HSP_FETCH;
                            next_s.rd = 1'b1;
                            next_s.idx = REGISTER_INDEX_LINES;
                        end
                    end
                end
            end
            hsp_pkg::HSP_FETCH: begin
                // REG_RDATA is valid while REG_RD is high.
                // [RL1] whole quadlet snapshot
                next_s.rshadow = REG_RDATA;
                next_s.st = hsp_pkg::HSP_READ;
            end
            hsp_pkg::HSP_READ: begin
                // Wait for the strobes to drop, so one cycle acts once.
                if (!any_act) begin
                    next_s.st = hsp_pkg::HSP_IDLE;
                end
            end
            hsp_pkg::HSP_WRITE: begin
                if (!any_act) begin
                    next_s.st = hsp_pkg::HSP_IDLE;
                end
            end
            default: begin
                // Illegal one-hot codes fall back to idle.
                next_s.st = hsp_pkg::HSP_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            s.st <= hsp_pkg::HSP_IDLE;
            s.rshadow <= hsp_pkg::SHADOW_RST;
            s.wshadow <= hsp_pkg::SHADOW_RST;
            s.idx <= hsp_pkg::IDX_RST;
            s.wdata <= hsp_pkg::SHADOW_RST;
            s.wr <= 1'b0;
            s.rd <= 1'b0;
            s.rx_err <= 1'b0;
            s.tx_err <= 1'b0;
        end else begin
            s <= next_s;
        end
    end

    // [RL2] combinational byte select
    // [RL5] lane changes never disturb the shadow
    assign HOST_DATA_LINES_OUT = lane_pick(s.rshadow, lane);
    // The enable follows the raw pins so the bus turns at once.
    assign HOST_DATA_LINES_OE = !HOST_CHIP_SELECT_N && !HOST_READ_STROBE_N
        && HOST_WRITE_STROBE_N;

    // The pin is only pulled low; a board pull-up gives the high level.
    // [RL21] open-drain request
    assign HOST_INTERRUPT_REQUEST_N_OUT = 1'b0;
    assign HOST_INTERRUPT_REQUEST_N_OE = INT_PENDING;

    // [RL23] six-bit register index
    assign REG_INDEX = s.idx;
    assign REG_WDATA = s.wdata;
    assign REG_WR = s.wr;
    assign REG_RD = s.rd;

    // [RL15] availability flags
    assign RXQ_AVAIL = rx_avail;
    assign TXQ_AVAIL = tx_room;
    assign RXQ_READ_ERR = s.rx_err;
    assign TXQ_WRITE_ERR = s.tx_err;
endmodule // hsp_port
`default_nettype wire

// file: rtl/hsp_pkg.sv
package hsp_pkg;

    localparam int QUAD_W = 32;
    localparam int BYTE_W = 8;
    localparam int LANE_W = 2;
    localparam int IDX_W = 6;
    localparam int NUM_LANES = 4;
    localparam int NUM_REGS = 64;
    localparam int NUM_RXQ = 2;
    localparam int NUM_TXQ = 2;
    localparam int SYNC_STAGES = 2;
    localparam int CTL_W = 3;

    // Register indices of the queue ports.
    localparam logic [IDX_W-1:0] RXQ_REQ_IDX = 6'h30;
    localparam logic [IDX_W-1:0] RXQ_RSP_IDX = 6'h31;
    localparam logic [IDX_W-1:0] TXQ_REQ_NEXT_IDX = 6'h32;
    localparam logic [IDX_W-1:0] TXQ_REQ_LAST_IDX = 6'h33;
    localparam logic [IDX_W-1:0] TXQ_RSP_NEXT_IDX = 6'h34;
    localparam logic [IDX_W-1:0] TXQ_RSP_LAST_IDX = 6'h35;

    localparam logic [QUAD_W-1:0] SHADOW_RST = 32'h0000_0000;
    localparam logic [IDX_W-1:0] IDX_RST = 6'h00;
    localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;

    typedef enum logic [3:0] {
        HSP_IDLE = 4'h1,
        HSP_FETCH = 4'h2,
        HSP_READ = 4'h4,
        HSP_WRITE = 4'h8
    } hsp_state_t;

endpackage

// file: rtl/hsp_hold_if.sv
`timescale 1ns/10ps
`default_nettype none
interface hsp_hold_if #(parameter int W = 32);
    logic [W-1:0] data;
    logic last;
    logic valid;
    logic ready;
    modport src (output data, output last, output valid, input ready);
    modport dst (input data, input last, input valid, output ready);
endinterface // hsp_hold_if
`default_nettype wire

// file: rtl/hsp_sync.sv
`timescale 1ns/10ps
`default_nettype none
module hsp_sync #(
    parameter int W = 3,
    parameter logic [W-1:0] RST_VAL = '1
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } hsp_sync_t;

    hsp_sync_t s;
    hsp_sync_t next_s;

    always_comb begin
        next_s.meta = d;
        next_s.stable = s.meta;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s <= {RST_VAL, RST_VAL};
        end else begin
            s <= next_s;
        end
    end

    assign q = s.stable;
endmodule // hsp_sync
`default_nettype wire

// file: rtl/hsp_holder.sv
`timescale 1ns/10ps
`default_nettype none
// One-quadlet transfer holder between host logic and queue storage.
module hsp_holder #(parameter int W = 32) (
    input wire logic clk,
    input wire logic rst_b,
    hsp_hold_if.dst up,
    hsp_hold_if.src dn
);
    typedef struct packed {
        logic full;
        logic last;
        logic [W-1:0] data;
    } hsp_holder_t;

    hsp_holder_t s;
    hsp_holder_t next_s;

    always_comb begin
        next_s = s;
        if (s.full && dn.ready) begin
            next_s.full = 1'b0;
        end
        if (up.valid && !s.full) begin
            next_s.full = 1'b1;
            next_s.last = up.last;
            next_s.data = up.data;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign up.ready = !s.full;
    assign dn.valid = s.full;
    assign dn.data = s.data;
    assign dn.last = s.last;
endmodule // hsp_holder
`default_nettype wire

// file: dv/hsp_port_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module hsp_port_monitor #(
    parameter int NRX = 2,
    parameter int NTX = 2
) (
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic BYTE_LANE_SELECT_LOW,
    input wire logic BYTE_LANE_SELECT_HIGH,
    input wire logic SHADOW_UPDATE_LINE,
    input wire logic HOST_READ_STROBE_N,
    input wire logic HOST_WRITE_STROBE_N,
    input wire logic HOST_CHIP_SELECT_N,
    input wire logic [hsp_pkg::BYTE_W-1:0] HOST_DATA_LINES_OUT,
    input wire logic HOST_DATA_LINES_OE,
    input wire logic HOST_INTERRUPT_REQUEST_N_OUT,
    input wire logic HOST_INTERRUPT_REQUEST_N_OE,
    input wire logic INT_PENDING,
    input wire logic [hsp_pkg::IDX_W-1:0] REG_INDEX,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [hsp_pkg::QUAD_W-1:0] REG_RDATA,
    input wire logic [NTX-1:0][hsp_pkg::QUAD_W-1:0] TXQ_DATA,
    input wire logic [NTX-1:0] TXQ_VALID,
    input wire logic [NTX-1:0] TXQ_READY,
    input wire logic [NTX-1:0] TXQ_AVAIL,
    input wire logic [NRX-1:0] RXQ_AVAIL,
    input wire logic RXQ_READ_ERR,
    input wire logic TXQ_WRITE_ERR
);
    default clocking mon_clk @(posedge CLK); endclocking
    default disable iff (!RST_B);
    a_oe_read_only: assert property (
        HOST_DATA_LINES_OE == (!HOST_CHIP_SELECT_N && !HOST_READ_STROBE_N && HOST_WRITE_STROBE_N))
        else $error("data enable does not follow a read cycle");
    a_wr_cause: assert property (
        REG_WR |-> $past(!HOST_WRITE_STROBE_N && !HOST_CHIP_SELECT_N && SHADOW_UPDATE_LINE, 2))
        else $error("register write without update write cycle");
    a_rd_cause: assert property (
        REG_RD |-> $past(HOST_WRITE_STROBE_N && !HOST_READ_STROBE_N && !HOST_CHIP_SELECT_N
            && SHADOW_UPDATE_LINE, 2))
        else $error("register fetch without update read cycle");
    a_wr_single: assert property (REG_WR |=> !REG_WR [*4])
        else $error("more than one register write per cycle");
    a_rd_single: assert property (REG_RD |=> !REG_RD [*4])
        else $error("more than one register fetch per cycle");
    a_rd_shadow: assert property (
        REG_RD |=> HOST_DATA_LINES_OUT == 8'($past(REG_RDATA)
            >> {~BYTE_LANE_SELECT_HIGH, ~BYTE_LANE_SELECT_LOW, 3'h0}))
        else $error("fetched byte not on data lines");
    a_irq_pin: assert property (
        !HOST_INTERRUPT_REQUEST_N_OUT && HOST_INTERRUPT_REQUEST_N_OE == INT_PENDING)
        else $error("interrupt pin does not mirror pending");
    a_index_hold: assert property ($changed(REG_INDEX) |-> $past(SHADOW_UPDATE_LINE, 2))
        else $error("register index moved without update");
    a_tx_holds: assert property (
        TXQ_VALID[0] && !TXQ_READY[0] |=> TXQ_VALID[0] && $stable(TXQ_DATA[0]))
        else $error("transmit holder dropped its quadlet");
    a_tx_err_full: assert property (TXQ_WRITE_ERR |-> $past(TXQ_AVAIL) != '1)
        else $error("push error while holders empty");
    c_write: cover property (REG_WR);
    c_fetch: cover property (REG_RD);
    c_rx_err: cover property (RXQ_READ_ERR);
    c_tx_err: cover property (TXQ_WRITE_ERR);
endmodule // hsp_port_monitor
bind hsp_port hsp_port_monitor #(.NRX(NRX), .NTX(NTX)) mon (.*);
`default_nettype wire

// file: dv/hsp_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// Byte-wide host; pins change on the falling clock edge, except a release with no hold, which acts at once.
module hsp_host_model (
    input wire logic clk,
    output logic a0,
    output logic a1,
    output logic [5:0] idx,
    output logic upd,
    output logic rd_n,
    output logic wr_n,
    output logic cs_n,
    output logic [7:0] din,
    input wire logic [7:0] dout,
    input wire logic oe
);
    logic [7:0] hd = 8'h00;
    logic drive = 1'h0;
    // Shared data wire: a released line shows the port's byte while oe is high, else the inverse of the last host byte.
    assign din = drive ? hd : (oe ? dout : ~hd);
    initial begin
        {a1, a0, idx, upd} = 9'h000;
        {rd_n, wr_n, cs_n} = 3'h7;
    end
    // Opens an access; index and data stay put until release, while lane() may step the lane lines.
    task automatic start(input logic r, input logic w, input logic u, input logic [5:0] i,
        input logic [1:0] l, input logic [7:0] d);
        @(negedge clk);
        {a1, a0} = l;
        idx = i;
        upd = u;
        hd = d;
        drive = w;
        cs_n = 1'h0;
        rd_n = ~r;
        wr_n = ~w;
    endtask
    task automatic lane(input logic [1:0] l);
        @(negedge clk);
        {a1, a0} = l;
    endtask
    // Release, then an idle gap above two core clocks.
    task automatic stop(input int hold);
        repeat (hold) @(negedge clk);
        {rd_n, wr_n, cs_n} = 3'h7;
        drive = 1'h0;
        repeat (4) @(negedge clk);
    endtask
endmodule // hsp_host_model
`default_nettype wire

// file: dv/hsp_port_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module hsp_port_tb_top;
    logic CLK, RST_B;
    logic a0, a1, upd, rd_n, wr_n, cs_n, oe, irq_out, irq_oe, int_pend, reg_wr, reg_rd;
    logic rx_err, tx_err;
    logic [5:0] idx, reg_index, wi;
    logic [7:0] din, dout;
    logic [31:0] reg_wdata, reg_rdata, wd;
    logic [1:0][31:0] rxq_data, txq_data;
    logic [1:0] rxq_valid, rxq_ready, txq_last, txq_valid, txq_ready, rxq_avail, txq_avail;
    int mismatches = 0, cmp_count = 0, nwr = 0, nrd = 0, nrxe = 0, ntxe = 0;
    // Register space answer: byte lane k of register i reads {k, i}.
    assign reg_rdata = {2'h0, reg_index, 2'h1, reg_index, 2'h2, reg_index, 2'h3, reg_index};
    hsp_port uut (
        .CLK(CLK), .RST_B(RST_B), .BYTE_LANE_SELECT_LOW(a0), .BYTE_LANE_SELECT_HIGH(a1),
        .REGISTER_INDEX_LINES(idx), .SHADOW_UPDATE_LINE(upd), .HOST_READ_STROBE_N(rd_n),
        .HOST_WRITE_STROBE_N(wr_n), .HOST_CHIP_SELECT_N(cs_n), .HOST_DATA_LINES_IN(din),
        .HOST_DATA_LINES_OUT(dout), .HOST_DATA_LINES_OE(oe),
        .HOST_INTERRUPT_REQUEST_N_OUT(irq_out), .HOST_INTERRUPT_REQUEST_N_OE(irq_oe),
        .INT_PENDING(int_pend), .REG_INDEX(reg_index), .REG_WDATA(reg_wdata), .REG_WR(reg_wr),
        .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .RXQ_DATA(rxq_data), .RXQ_VALID(rxq_valid),
        .RXQ_READY(rxq_ready), .TXQ_DATA(txq_data), .TXQ_LAST(txq_last), .TXQ_VALID(txq_valid),
        .TXQ_READY(txq_ready), .RXQ_AVAIL(rxq_avail), .TXQ_AVAIL(txq_avail),
        .RXQ_READ_ERR(rx_err), .TXQ_WRITE_ERR(tx_err));
    hsp_host_model host (.clk(CLK), .a0(a0), .a1(a1), .idx(idx), .upd(upd), .rd_n(rd_n),
        .wr_n(wr_n), .cs_n(cs_n), .din(din), .dout(dout), .oe(oe));
    // One-cycle pulses are counted mid-cycle, away from the launching edge.
    always @(negedge CLK) begin
        if (reg_wr === 1'h1) begin
            nwr++;
            wd = reg_wdata;
            wi = reg_index;
        end
        if (reg_rd === 1'h1) nrd++;
        if (rx_err === 1'h1) nrxe++;
        if (tx_err === 1'h1) ntxe++;
    end
    task automatic close_out();
        $display("Comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic acc(input logic w, input logic u, input logic [5:0] i, input logic [1:0] l,
        input logic [7:0] d);
        host.start(~w, w, u, i, l, d);
        host.stop(6);
    endtask
    // Steps the lane lines inside one held read, last lane first.
    task automatic see4(input logic [31:0] q);
        for (int k = 3; k >= 0; k--) begin
            host.lane(2'(k));
            #10;
            chk("read byte", 32'(q[31-8*k -: 8]), 32'(dout));
        end
    endtask
    task automatic wait_hi(input int sel);
        int n;
        for (n = 0; n < 20; n++) begin
            @(negedge CLK);
            if ((sel == 0 ? rxq_avail[0] : txq_avail[0]) === 1'h1) break;
        end
        if (n == 20) begin
            chk("holder status", 32'h1, 32'h0);
            close_out();
        end
    endtask
    task automatic sc_write();
        int w0;
        w0 = nwr;
        for (int k = 0; k < 3; k++) acc(1, 0, 6'h3F, 2'(k), 8'(8'h11 * (k + 1)));
        chk("writes without update", 32'(w0), 32'(nwr));
        acc(1, 1, 6'h05, 2'h3, 8'h44);
        chk("write quadlet", 32'h11223344, wd);
        chk("write index", 32'h5, 32'(wi));
        acc(1, 1, 6'h09, 2'h3, 8'h55);
        chk("stale lanes", 32'h11223355, wd);
        chk("write count", 32'(w0 + 2), 32'(nwr));
    endtask
    task automatic sc_read();
        int r0;
        r0 = nrd;
        host.start(1, 0, 1, 6'h07, 2'h0, 8'h00);
        repeat (6) @(negedge CLK);
        chk("data enable", 32'h1, 32'(oe));
        see4(32'h074787C7);
        host.stop(0);
        host.start(1, 0, 0, 6'h3F, 2'h1, 8'h00);
        repeat (6) @(negedge CLK);
        see4(32'h074787C7);
        host.stop(0);
        chk("fetch count", 32'(r0 + 1), 32'(nrd));
    endtask
    task automatic sc_both();
        host.start(1, 1, 1, 6'h02, 2'h0, 8'hAA);
        repeat (6) @(negedge CLK);
        chk("data enable both", 32'h0, 32'(oe));
        host.stop(0);
        chk("both strobes quadlet", 32'hAA223355, wd);
        chk("both strobes index", 32'h2, 32'(wi));
    endtask
    task automatic pop(input logic [31:0] q, input int hold);
        host.start(1, 0, 1, 6'h30, 2'h0, 8'h00);
        repeat (hold) @(negedge CLK);
        see4(q);
        host.stop(0);
    endtask
    task automatic sc_rx();
        int r0;
        r0 = nrd;
        rxq_data[0] = 32'h12345678;
        rxq_valid[0] = 1'h1;
        wait_hi(0);
        chk("rx holder ready", 32'h0, 32'(rxq_ready[0]));
        rxq_data[0] = 32'h9ABCDEF0;
        pop(32'h12345678, 12);
        wait_hi(0);
        rxq_valid[0] = 1'h0;
        pop(32'h9ABCDEF0, 6);
        chk("pop empty flag", 32'h0, 32'(rxq_avail[0]));
        chk("rx holder free", 32'h1, 32'(rxq_ready[0]));
        pop(32'h9ABCDEF0, 6);
        chk("pop errors", 32'h1, 32'(nrxe));
        chk("queue fetches", 32'(r0), 32'(nrd));
    endtask
    task automatic sc_tx();
        int w0;
        w0 = nwr;
        txq_ready = 2'h0;
        acc(1, 1, 6'h32, 2'h3, 8'h01);
        chk("tx quadlet", 32'hAA223301, txq_data[0]);
        chk("tx valid last", 32'h2, 32'({txq_valid[0], txq_last[0]}));
        acc(1, 1, 6'h33, 2'h3, 8'h02);
        chk("push errors", 32'h1, 32'(ntxe));
        chk("tx kept", 32'hAA223301, txq_data[0]);
        txq_ready[0] = 1'h1;
        wait_hi(1);
        txq_ready[0] = 1'h0;
        acc(1, 1, 6'h33, 2'h3, 8'h02);
        chk("tx last quadlet", 32'hAA223302, txq_data[0]);
        chk("tx valid last", 32'h3, 32'({txq_valid[0], txq_last[0]}));
        acc(1, 1, 6'h34, 2'h3, 8'h03);
        chk("tx second queue", 32'hAA223303, txq_data[1]);
        chk("tx second flags", 32'h2, 32'({txq_valid[1], txq_last[1]}));
        chk("queue writes", 32'(w0), 32'(nwr));
        txq_ready = 2'h3;
    endtask
    task automatic sc_int();
        @(negedge CLK);
        int_pend = 1'h1;
        @(negedge CLK);
        chk("irq enable", 32'h1, 32'(irq_oe));
        chk("irq level", 32'h0, 32'(irq_out));
        int_pend = 1'h0;
        @(negedge CLK);
        chk("irq released", 32'h0, 32'(irq_oe));
    endtask
    initial begin
        CLK = 1'h0;
        forever #50 CLK = ~CLK;
    end
    initial begin
        RST_B = 1'h0;
        int_pend = 1'h0;
        rxq_valid = 2'h0;
        rxq_data = '0;
        txq_ready = 2'h3;
        repeat (10) @(negedge CLK);
        chk("reset data lines", 32'h0, 32'(dout));
        RST_B = 1'h1;
        sc_write();
        sc_read();
        sc_both();
        sc_rx();
        sc_tx();
        sc_int();
        close_out();
    end
    initial begin
        repeat (20000) @(posedge CLK);
        chk("run length", 32'h0, 32'h1);
        close_out();
    end
endmodule // hsp_port_tb_top
`default_nettype wire
